/* File: las_scan_top.sv */
// Purpose: Pixel memory addressing, display latch and common scan
// Assumes: Host commands and data arrive on a plain strobe port
// Notes: Display clock pin is asynchronous and is synchronised first
`timescale 1ns/100ps
`default_nettype none
`include "las_consts.svh"
module las_scan_top (
	input wire logic mclk_in,
	input wire logic sys_rst_in,
	input wire logic clk_en_in,
	input wire logic bus_wr_in,
	input wire logic bus_rd_in,
	input wire logic data_command_select_in,
	input wire logic [7:0] bus_wdata_in,
	output logic [7:0] bus_rdata_out,
	input wire logic display_clock_input_in,
	output logic [131:0] segment_outputs_out,
	output logic [63:0] common_outputs_out,
	output logic indicator_common_output_out,
	output logic frame_inversion_signal_out,
	output las_pkg::las_seg_lvl_t segment_level_out,
	output las_pkg::las_com_lvl_t common_level_out,
	output logic [1:0] indicator_level_out,
	output logic internal_clock_out,
	output las_pkg::las_pwr_t power_ctrl_out,
	output las_pkg::las_cfg_t display_cfg_out,
	output logic [7:0] column_out,
	output logic [3:0] page_out
);
	import las_pkg::*;

	// ----------------------------------------------------------------
	// Host port decode
	// ----------------------------------------------------------------
	wire data_wr = bus_wr_in && data_command_select_in;
	wire data_rd = bus_rd_in && data_command_select_in;
	wire cmd_wr = bus_wr_in && !data_command_select_in;
	wire data_acc = data_wr || data_rd;
	// A data access needs the select line high and a command needs it
	// low, so a data access and a command never fall in the same cycle

	wire is_col_lo = cmd_wr && bus_wdata_in[7:4] == `LAS_CMD_COL_LO;
	wire is_col_hi = cmd_wr && bus_wdata_in[7:4] == `LAS_CMD_COL_HI;
	wire is_page = cmd_wr && bus_wdata_in[7:4] == `LAS_CMD_PAGE;
	wire is_start = cmd_wr && bus_wdata_in[7:6] == `LAS_CMD_START;
	wire is_power = cmd_wr && bus_wdata_in[7:3] == `LAS_CMD_POWER;
	wire is_seg_dir = cmd_wr && bus_wdata_in[7:1] == `LAS_CMD_SEG_DIR;
	wire is_all_on = cmd_wr && bus_wdata_in[7:1] == `LAS_CMD_ALL_ON;
	wire is_inverse = cmd_wr && bus_wdata_in[7:1] == `LAS_CMD_INVERSE;
	wire is_disp_on = cmd_wr && bus_wdata_in[7:1] == `LAS_CMD_DISP_ON;
	wire is_com_dir = cmd_wr && bus_wdata_in[7:4] == `LAS_CMD_COM_DIR;
	// Pages above the indicator page do not exist and are refused
	wire page_ok = bus_wdata_in[3:0] <= `LAS_IND_PAGE;

	// ----------------------------------------------------------------
	// Host column and page counters
	// ----------------------------------------------------------------
	logic [7:0] col_r;
	logic [7:0] col_nxt;
	logic [3:0] page_r;
	logic [3:0] page_nxt;
	// A column set past the end counts as the last column
	wire at_last_col = col_r >= `LAS_LAST_COL;
	wire at_last_page = page_r == `LAS_IND_PAGE;

	always_comb begin
		col_nxt = col_r;
		page_nxt = page_r;
		if (data_acc) begin
			if (at_last_col) begin
				col_nxt = 8'h00;
				page_nxt = at_last_page ? 4'h0 : 4'(page_r + 4'h1);
			end else begin
				col_nxt = 8'(col_r + 8'h01);
			end
		end else if (is_col_lo) begin
			col_nxt = {col_r[7:4], bus_wdata_in[3:0]};
		end else if (is_col_hi) begin
			col_nxt = {bus_wdata_in[3:0], col_r[3:0]};
		end else if (is_page && page_ok) begin
			page_nxt = bus_wdata_in[3:0];
		end
	end

	// Clock enable low freezes counters, latch and memory writes alike
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			col_r <= 8'h00;
			page_r <= 4'h0;
		end else if (clk_en_in) begin
			col_r <= col_nxt;
			page_r <= page_nxt;
		end
	end

	assign column_out = col_r;
	assign page_out = page_r;

	// ----------------------------------------------------------------
	// Pixel memory and read pipeline
	// ----------------------------------------------------------------
	wire [7:0] safe_col = at_last_col ? `LAS_LAST_COL : col_r;
	wire [10:0] host_addr = 11'(page_r * `LAS_NUM_COLS + safe_col);
	// Indicator page keeps only the bit that drives its row
	wire [7:0] wr_byte = at_last_page ? {7'h00, bus_wdata_in[0]} :
		bus_wdata_in;
	wire [7:0] mem_rdata;
	wire [131:0] scan_row;
	logic [3:0] scan_page;
	logic [2:0] scan_bit;
	logic [7:0] holder_r;
	logic [7:0] rdata_r;

	// Refresh reads its own row port, so host writes never wait for
	// it and reach the segments when their line is next latched, even in mid-frame
	las_pixmem u_mem (
		.mclk_in(mclk_in),
		.clk_en_in(clk_en_in),
		.wr_in(data_wr),
		.addr_in(host_addr),
		.wdata_in(wr_byte),
		.rdata_out(mem_rdata),
		.scan_page_in(scan_page),
		.scan_bit_in(scan_bit),
		.scan_row_out(scan_row)
	);

	// The host sees the byte fetched by its previous read
	// Command reads answer zero, as there is no status to report
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			holder_r <= 8'h00;
			rdata_r <= 8'h00;
		end else if (clk_en_in) begin
			rdata_r <= data_rd ? holder_r : 8'h00;
			if (data_rd) begin
				holder_r <= mem_rdata;
			end
		end
	end

	assign bus_rdata_out = rdata_r;

	// ----------------------------------------------------------------
	// Display settings and power control
	// ----------------------------------------------------------------
	las_cfg_t cfg_r;
	las_pwr_t pwr_r;
	logic [5:0] start_r;
	// Settings steer only the latch path; pixel memory is never touched

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			cfg_r <= '0;
			pwr_r <= '0;
			start_r <= 6'h00;
		end else if (clk_en_in) begin
			if (is_start) begin
				start_r <= bus_wdata_in[5:0];
			end
			if (is_power) begin
				pwr_r <= bus_wdata_in[2:0];
			end
			if (is_seg_dir) begin
				cfg_r.seg_rev <= bus_wdata_in[0];
			end
			if (is_com_dir) begin
				cfg_r.com_rev <= bus_wdata_in[3];
			end
			if (is_disp_on) begin
				cfg_r.disp_on <= bus_wdata_in[0];
			end
			if (is_inverse) begin
				cfg_r.inverse <= bus_wdata_in[0];
			end
			if (is_all_on) begin
				cfg_r.all_on <= bus_wdata_in[0];
			end
		end
	end

	assign power_ctrl_out = pwr_r;
	assign display_cfg_out = cfg_r;

	// ----------------------------------------------------------------
	// Display clock source
	// ----------------------------------------------------------------
	logic clk_s1_r;
	logic clk_s2_r;
	logic clk_s3_r;
	logic [15:0] hold_r;
	logic [15:0] osc_r;
	logic int_sel_r;
	// A free-running external clock never stays high this long
	wire hold_done = hold_r == 16'(`LAS_HOLD_CYC);
	wire osc_wrap = osc_r == 16'(`LAS_OSC_DIV - 16'd1);
	wire ext_edge = clk_s2_r && !clk_s3_r;
	wire disp_tick = int_sel_r ? osc_wrap : ext_edge;
	// Only the second flop feeds logic; the third only marks the edge.
	// One low sample drops internal mode, so a stopped external clock
	// that restarts takes over at once instead of waiting out a filter

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			clk_s1_r <= 1'b0;
			clk_s2_r <= 1'b0;
			clk_s3_r <= 1'b0;
			hold_r <= 16'h0000;
			osc_r <= 16'h0000;
			int_sel_r <= 1'b0;
		end else if (clk_en_in) begin
			clk_s1_r <= display_clock_input_in;
			clk_s2_r <= clk_s1_r;
			clk_s3_r <= clk_s2_r;
			if (!clk_s2_r) begin
				hold_r <= 16'h0000;
			end else if (!hold_done) begin
				hold_r <= 16'(hold_r + 16'h0001);
			end
			int_sel_r <= hold_done;
			osc_r <= osc_wrap ? 16'h0000 : 16'(osc_r + 16'h0001);
		end
	end

	assign internal_clock_out = int_sel_r;

	// ----------------------------------------------------------------
	// Refresh line counter and frame inversion
	// ----------------------------------------------------------------
	logic [6:0] scan_r;
	logic fr_r;
	wire scan_ind = scan_r == `LAS_LAST_LINE;
	wire [5:0] line_addr = 6'(start_r + scan_r[5:0]);
	// Line 64 is the indicator line, fed from bit zero of the last
	// page, and the frame inverts only as that line is latched

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			scan_r <= 7'h00;
			fr_r <= 1'b0;
		end else if (clk_en_in && disp_tick) begin
			if (scan_ind) begin
				scan_r <= 7'h00;
				fr_r <= !fr_r;
			end else begin
				scan_r <= 7'(scan_r + 7'h01);
			end
		end
	end

	always_comb begin
		scan_page = scan_ind ? `LAS_IND_PAGE : {1'b0, line_addr[5:3]};
		scan_bit = scan_ind ? 3'h0 : line_addr[2:0];
	end

	// ----------------------------------------------------------------
	// Display data latch
	// ----------------------------------------------------------------
	logic [131:0] seg_nxt;
	logic [63:0] com_nxt;
	logic [131:0] seg_r;
	logic [63:0] com_r;
	logic ind_r;
	wire [5:0] com_idx = cfg_r.com_rev ? 6'(`LAS_COM_LAST - scan_r[5:0]) :
		scan_r[5:0];

	genvar n;
	generate
		for (n = 0; n < `LAS_NUM_COLS; n = n + 1) begin : g_seg
			wire pix = cfg_r.seg_rev ? scan_row[`LAS_NUM_COLS - 1 - n] :
				scan_row[n];
			assign seg_nxt[n] = cfg_r.disp_on &&
				(cfg_r.all_on || (pix ^ cfg_r.inverse));
		end
	endgenerate

	// Commons stay deselected while the indicator line is shown
	always_comb begin
		com_nxt = 64'h0;
		if (!scan_ind) begin
			com_nxt[com_idx] = 1'b1;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			seg_r <= 132'h0;
			com_r <= 64'h0;
			ind_r <= 1'b0;
		end else if (clk_en_in && disp_tick) begin
			seg_r <= seg_nxt;
			com_r <= com_nxt;
			ind_r <= scan_ind;
		end
	end

	assign segment_outputs_out = seg_r;
	assign common_outputs_out = com_r;
	assign indicator_common_output_out = ind_r;
	assign frame_inversion_signal_out = fr_r;

	// ----------------------------------------------------------------
	// Drive level selection
	// ----------------------------------------------------------------
	// Level codes lag the latch by one clock so the pads see no glitch
	las_drv_mux u_drv (
		.mclk_in(mclk_in),
		.sys_rst_in(sys_rst_in),
		.clk_en_in(clk_en_in),
		.seg_on_in(seg_r),
		.com_sel_in(com_r),
		.ind_sel_in(ind_r),
		.fr_in(fr_r),
		.seg_lvl_out(segment_level_out),
		.com_lvl_out(common_level_out),
		.ind_lvl_out(indicator_level_out)
	);
endmodule
`default_nettype wire

/* File: las_consts.svh */
// Purpose: Named constants for the pixel memory addressing and scan block
// Assumes: 100 MHz system clock
// Notes: Command codes, geometry, drive level codes and timing counts
`ifndef LAS_CONSTS_SVH
`define LAS_CONSTS_SVH

// ----------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------
`define LAS_NUM_COLS 132
`define LAS_NUM_PAGES 9
`define LAS_NUM_INDICATOR_COMMON_OUTPUT 64
`define LAS_MEM_WORDS 1188
`define LAS_LAST_COL 8'h83
`define LAS_IND_PAGE 4'h8
`define LAS_LAST_LINE 7'h40
`define LAS_COM_LAST 6'h3f
`define LAS_SEG_LAST 8'h83

// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define LAS_CMD_COL_LO 4'h0
`define LAS_CMD_COL_HI 4'h1
`define LAS_CMD_PAGE 4'hb
`define LAS_CMD_START 2'h1
`define LAS_CMD_POWER 5'h05
`define LAS_CMD_SEG_DIR 7'h50
`define LAS_CMD_ALL_ON 7'h52
`define LAS_CMD_INVERSE 7'h53
`define LAS_CMD_DISP_ON 7'h57
`define LAS_CMD_COM_DIR 4'hc

// ----------------------------------------------------------------
// Drive level codes, highest voltage first
// ----------------------------------------------------------------
`define LAS_LVL_V0 2'h0
`define LAS_LVL_V1 2'h1
`define LAS_LVL_V2 2'h2
`define LAS_LVL_VSS 2'h3
`define LAS_LVL_V3 2'h1
`define LAS_LVL_V4 2'h2

// ----------------------------------------------------------------
// Display clock
// ----------------------------------------------------------------
`define LAS_CLK_MHZ 100
`define LAS_HOLD_US 40
`define LAS_HOLD_CYC (`LAS_HOLD_US * `LAS_CLK_MHZ)
`define LAS_OSC_DIV 16'd1000

`endif

/* File: las_pkg.sv */
// Purpose: Shared types for the pixel memory addressing and scan block
// Assumes: Nothing beyond las_consts.svh
// Notes: Configuration and power control travel as packed structs
package las_pkg;

	typedef struct packed {
		logic seg_rev;
		logic com_rev;
		logic disp_on;
		logic inverse;
		logic all_on;
	} las_cfg_t;

	typedef struct packed {
		logic booster;
		logic regulator;
		logic follower;
	} las_pwr_t;

	typedef logic [131:0][1:0] las_seg_lvl_t;
	typedef logic [63:0][1:0] las_com_lvl_t;

endpackage

/* File: las_pixmem.sv */
// Purpose: Pixel memory, 9 pages by 132 columns of bytes
// Assumes: One host port and one full-row scan port, same clock
// Notes: Scan row read is combinational and never touches the host port
`timescale 1ns/100ps
`default_nettype none
`include "las_consts.svh"
module las_pixmem (
	input wire logic mclk_in,
	input wire logic clk_en_in,
	input wire logic wr_in,
	input wire logic [10:0] addr_in,
	input wire logic [7:0] wdata_in,
	output logic [7:0] rdata_out,
	input wire logic [3:0] scan_page_in,
	input wire logic [2:0] scan_bit_in,
	output logic [131:0] scan_row_out
);
	import las_pkg::*;

	logic [7:0] mem [0:`LAS_MEM_WORDS-1];
	logic [10:0] scan_base;

	always_ff @(posedge mclk_in) begin
		if (clk_en_in && wr_in) begin
			mem[addr_in] <= wdata_in;
		end
	end

	assign rdata_out = mem[addr_in];
	assign scan_base = 11'(scan_page_in * `LAS_NUM_COLS);

	// ----------------------------------------------------------------
	// Scan read, one bit from each column
	// ----------------------------------------------------------------
	genvar c;
	generate
		for (c = 0; c < `LAS_NUM_COLS; c = c + 1) begin : g_col
			wire [10:0] idx = 11'(scan_base + c);
			assign scan_row_out[c] = mem[idx][scan_bit_in];
		end
	endgenerate
endmodule
`default_nettype wire

/* File: las_drv_mux.sv */
// Purpose: Four-level drive selection for segment and common outputs
// Assumes: Inputs come from the display latch on the same clock
// Notes: Level codes are registered so the pads never see mux glitches
`timescale 1ns/100ps
`default_nettype none
`include "las_consts.svh"
module las_drv_mux (
	input wire logic mclk_in,
	input wire logic sys_rst_in,
	input wire logic clk_en_in,
	input wire logic [131:0] seg_on_in,
	input wire logic [63:0] com_sel_in,
	input wire logic ind_sel_in,
	input wire logic fr_in,
	output las_pkg::las_seg_lvl_t seg_lvl_out,
	output las_pkg::las_com_lvl_t com_lvl_out,
	output logic [1:0] ind_lvl_out
);
	import las_pkg::*;

	las_seg_lvl_t seg_nxt;
	las_com_lvl_t com_nxt;
	logic [1:0] ind_nxt;

	genvar i;
	generate
		for (i = 0; i < `LAS_NUM_COLS; i = i + 1) begin : g_seg
			assign seg_nxt[i] = fr_in ?
				(seg_on_in[i] ? `LAS_LVL_V0 : `LAS_LVL_V2) :
				(seg_on_in[i] ? `LAS_LVL_VSS : `LAS_LVL_V3);
		end
		for (i = 0; i < `LAS_NUM_INDICATOR_COMMON_OUTPUT; i = i + 1) begin : g_com
			assign com_nxt[i] = fr_in ?
				(com_sel_in[i] ? `LAS_LVL_VSS : `LAS_LVL_V1) :
				(com_sel_in[i] ? `LAS_LVL_V0 : `LAS_LVL_V4);
		end
	endgenerate

	assign ind_nxt = fr_in ?
		(ind_sel_in ? `LAS_LVL_VSS : `LAS_LVL_V1) :
		(ind_sel_in ? `LAS_LVL_V0 : `LAS_LVL_V4);

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			seg_lvl_out <= '0;
			com_lvl_out <= '0;
			ind_lvl_out <= 2'h0;
		end else if (clk_en_in) begin
			seg_lvl_out <= seg_nxt;
			com_lvl_out <= com_nxt;
			ind_lvl_out <= ind_nxt;
		end
	end
endmodule
`default_nettype wire

/* File: las_scan_assertions.sv */
// Purpose: Port checks for the pixel memory addressing and scan block
// Assumes: One clock, synchronous active high reset
// Notes: Counter checks are exact, scan checks allow the latch lag
`timescale 1ns/100ps
`default_nettype none
module las_scan_chk (
	input wire logic mclk_in,
	input wire logic sys_rst_in,
	input wire logic clk_en_in,
	input wire logic bus_wr_in,
	input wire logic bus_rd_in,
	input wire logic data_command_select_in,
	input wire logic [7:0] bus_wdata_in,
	input wire logic [7:0] bus_rdata_out,
	input wire logic indicator_common_output_out,
	input wire logic frame_inversion_signal_out,
	input wire las_pkg::las_pwr_t power_ctrl_out,
	input wire logic [7:0] column_out,
	input wire logic [3:0] page_out
);
	import las_pkg::*;
	wire dsel = data_command_select_in;
	wire acc = clk_en_in & dsel & (bus_wr_in | bus_rd_in);
	wire is_cmd = clk_en_in & !dsel & bus_wr_in;
	wire at_end = column_out >= 8'h83;
	wire pg_cmd = is_cmd & (bus_wdata_in[7:4] == 4'hb);
	wire [3:0] pg_arg = bus_wdata_in[3:0];
	wire [2:0] pwr_arg = bus_wdata_in[2:0];
	default clocking @(posedge mclk_in); endclocking
	default disable iff (sys_rst_in);
	// ----------------------------------------------------------------
	// Host counters
	// ----------------------------------------------------------------
	a_col_step: assert property (
		acc && !at_end |=> column_out == $past(column_out) + 8'h01
		&& $stable(page_out)) else $error("column did not step");
	a_page_wrap: assert property (
		acc && at_end && page_out < 4'h8 |=> column_out == 8'h00
		&& page_out == $past(page_out) + 4'h1) else $error("no page wrap");
	a_end_wrap: assert property (
		acc && at_end && page_out == 4'h8 |=> column_out == 8'h00
		&& page_out == 4'h0) else $error("no wrap at memory end");
	a_page_set: assert property (
		pg_cmd && pg_arg <= 4'h8 |=> page_out == $past(pg_arg))
		else $error("page command not taken");
	a_page_keep: assert property (
		pg_cmd && pg_arg > 4'h8 |=> $stable(page_out))
		else $error("bad page value taken");
	a_host_only: assert property (
		$changed(column_out) || $changed(page_out)
		|-> $past(clk_en_in && (bus_wr_in || bus_rd_in)))
		else $error("counters moved without host strobe");
	// ----------------------------------------------------------------
	// Bus answers, power and frame
	// ----------------------------------------------------------------
	a_cmd_read: assert property (
		clk_en_in && bus_rd_in && !dsel |=> bus_rdata_out == 8'h00)
		else $error("command read returned data");
	a_pwr_set: assert property (
		is_cmd && bus_wdata_in[7:3] == 5'h05
		|=> power_ctrl_out == $past(pwr_arg)) else $error("power bits");
	a_fr_frame: assert property (
		$changed(frame_inversion_signal_out) |-> indicator_common_output_out
		|| $past(indicator_common_output_out)) else $error("fr mid frame");
	c_end_wrap: cover property (acc && at_end && page_out == 4'h8);
	c_fr_flip: cover property ($changed(frame_inversion_signal_out));
	c_pwr_cmd: cover property (is_cmd && bus_wdata_in[7:3] == 5'h05);
endmodule
bind las_scan_top las_scan_chk u_chk (.mclk_in, .sys_rst_in, .clk_en_in,
	.bus_wr_in, .bus_rd_in, .data_command_select_in, .bus_wdata_in,
	.bus_rdata_out, .indicator_common_output_out,
	.frame_inversion_signal_out, .power_ctrl_out, .column_out, .page_out);
`default_nettype wire

/* File: las_host_model.sv */
// Purpose: Host processor model issuing commands and pixel data
// Assumes: Strobes sampled on rising edges, read data one cycle later
// Notes: Released data bus shows the inverted byte, not the old one
`timescale 1ns/100ps
`default_nettype none
module las_host_model (
	input wire logic mclk_in,
	input wire logic [7:0] rdata_in,
	output var logic wr_out,
	output var logic rd_out,
	output var logic sel_out,
	output var logic [7:0] wdata_out
);
	initial begin
		wr_out = 1'b0;
		rd_out = 1'b0;
		sel_out = 1'b0;
		wdata_out = 8'h00;
	end
	task automatic wr(input logic sel, input logic [7:0] d);
		@(posedge mclk_in);
		wr_out <= 1'b1;
		sel_out <= sel;
		wdata_out <= d;
		@(posedge mclk_in);
		wr_out <= 1'b0;
		wdata_out <= ~d;
		// Let the counters settle before the caller looks at them
		#1;
	endtask
	task automatic rd(input logic sel, output logic [7:0] q);
		@(posedge mclk_in);
		rd_out <= 1'b1;
		sel_out <= sel;
		@(posedge mclk_in);
		rd_out <= 1'b0;
		#1 q = rdata_in;
	endtask
	task automatic seek(input logic [3:0] pg, input logic [7:0] col);
		wr(1'b0, {4'hb, pg});
		wr(1'b0, {4'h0, col[3:0]});
		wr(1'b0, {4'h1, col[7:4]});
	endtask
	// First read after an address set only primes the holder
	task automatic fetch(input logic [3:0] pg, input logic [7:0] col,
		output logic [7:0] q);
		seek(pg, col);
		rd(1'b1, q);
		rd(1'b1, q);
	endtask
	task automatic pwr(input logic on);
		wr(1'b0, {5'h05, {3{on}}});
	endtask
endmodule
`default_nettype wire

/* File: test_lcd_ram_addressing_scan.sv */
// Purpose: Self-checking bench for the addressing and scan block
// Assumes: External display clock except in the oscillator case
// Notes: Memory is unreset, so only written cells are compared
`timescale 1ns/100ps
`default_nettype none
`include "las_consts.svh"
module test_lcd_ram_addressing_scan;
	import las_pkg::*;
	typedef struct packed {
		logic [3:0] pg;
		logic [7:0] col, dat, rd, ncol;
		logic [3:0] npg;
	} las_row_t;
	las_row_t rows [5] = '{{4'h0, 8'h00, 8'ha5, 8'ha5, 8'h01, 4'h0},
		{4'h3, 8'h25, 8'h3c, 8'h3c, 8'h26, 4'h3},
		{4'h2, 8'h83, 8'h81, 8'h81, 8'h00, 4'h3},
		{4'h8, 8'h10, 8'hff, 8'h01, 8'h11, 4'h8},
		{4'h8, 8'h83, 8'hfe, 8'h00, 8'h00, 4'h0}};
	logic mclk_in, sys_rst_in, clk_en_in, pin, wr, rd, sel, ind, fr, intc;
	logic [7:0] wdata, rdata, col, q;
	logic [131:0] seg;
	logic [63:0] com;
	logic [3:0] pg;
	las_seg_lvl_t seg_lvl;
	las_com_lvl_t com_lvl;
	logic [1:0] ind_lvl;
	las_pwr_t pwr;
	las_cfg_t cfg;
	las_row_t r;
	logic f;
	int mismatches, total_checks;
	las_scan_top DUT (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
		.clk_en_in(clk_en_in), .bus_wr_in(wr), .bus_rd_in(rd),
		.data_command_select_in(sel), .bus_wdata_in(wdata),
		.bus_rdata_out(rdata), .display_clock_input_in(pin),
		.segment_outputs_out(seg), .common_outputs_out(com),
		.indicator_common_output_out(ind),
		.frame_inversion_signal_out(fr), .segment_level_out(seg_lvl),
		.common_level_out(com_lvl), .indicator_level_out(ind_lvl),
		.internal_clock_out(intc), .power_ctrl_out(pwr),
		.display_cfg_out(cfg), .column_out(col), .page_out(pg));
	las_host_model HOST (.mclk_in(mclk_in), .rdata_in(rdata), .wr_out(wr),
		.rd_out(rd), .sel_out(sel), .wdata_out(wdata));
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task chk(input logic [7:0] s, input logic [7:0] e);
		@(negedge mclk_in);
		total_checks++;
		if (s !== e) begin
			mismatches++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task stop_test;
		if (mismatches == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// One display clock pulse, pin left low while stopped
	task tick;
		@(posedge mclk_in) pin <= 1'b1;
		repeat (5) @(posedge mclk_in);
		pin <= 1'b0;
		repeat (5) @(posedge mclk_in);
	endtask
	task scan_to(input int k);
		tick;
		for (int n = 0; n < 70 && com[k] !== 1'b1; n++)
			tick;
	endtask
	initial begin
		mclk_in = 1'b0;
		forever #5 mclk_in = ~mclk_in;
	end
	initial begin
		repeat (40000) @(posedge mclk_in);
		mismatches++;
		stop_test;
	end
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		sys_rst_in = 1'b1;
		clk_en_in = 1'b1;
		pin = 1'b0;
		repeat (20) @(posedge mclk_in);
		sys_rst_in <= 1'b0;
		for (int i = 0; i < 5; i++) begin
			r = rows[i];
			HOST.seek(r.pg, r.col);
			HOST.wr(1'b1, r.dat);
			chk(col, r.ncol);
			chk(8'(pg), 8'(r.npg));
			HOST.fetch(r.pg, r.col, q);
			chk(q, r.rd);
		end
		HOST.wr(1'b0, 8'hb9);
		chk(8'(pg), 8'h00);
		HOST.rd(1'b0, q);
		chk(q, 8'h00);
		HOST.seek(4'h0, 8'h00);
		HOST.wr(1'b1, 8'h01);
		HOST.seek(4'h0, 8'h83);
		HOST.wr(1'b1, 8'h00);
		HOST.wr(1'b0, 8'haf);
		scan_to(0);
		chk(8'(seg[0]), 8'h01);
		chk(8'(seg[131]), 8'h00);
		chk(8'(seg_lvl[0]), 8'(fr ? `LAS_LVL_V0 : `LAS_LVL_VSS));
		f = fr;
		repeat (65) tick;
		chk(8'(com[0]), 8'h01);
		chk(8'(fr), 8'(!f));
		chk(8'(com_lvl[0]), 8'(fr ? `LAS_LVL_VSS : `LAS_LVL_V0));
		chk(8'(ind_lvl), 8'(fr ? `LAS_LVL_V1 : `LAS_LVL_V4));
		HOST.wr(1'b0, 8'ha1);
		scan_to(0);
		chk(8'(seg[131]), 8'h01);
		HOST.wr(1'b0, 8'h41);
		scan_to(63);
		chk(8'(seg[131]), 8'h01);
		HOST.wr(1'b0, 8'hc8);
		scan_to(0);
		chk(8'(seg[131]), 8'h01);
		HOST.wr(1'b0, 8'ha7);
		scan_to(0);
		chk(8'(seg[131]), 8'h00);
		HOST.wr(1'b0, 8'ha5);
		chk(8'(cfg), 8'h1f);
		scan_to(0);
		chk(8'(seg[5]), 8'h01);
		HOST.fetch(4'h0, 8'h00, q);
		chk(q, 8'h01);
		pin <= 1'b1;
		repeat (4010) @(posedge mclk_in);
		chk(8'(intc), 8'h01);
		pin <= 1'b0;
		repeat (5) @(posedge mclk_in);
		chk(8'(intc), 8'h00);
		HOST.pwr(1'b1);
		chk(8'(pwr), 8'h07);
		@(posedge mclk_in) clk_en_in <= 1'b0;
		HOST.wr(1'b1, 8'h55);
		chk(col, 8'h02);
		@(posedge mclk_in) clk_en_in <= 1'b1;
		@(posedge mclk_in) sys_rst_in <= 1'b1;
		repeat (20) @(posedge mclk_in);
		sys_rst_in <= 1'b0;
		chk(8'(pwr), 8'h00);
		chk(col, 8'h00);
		stop_test;
	end
endmodule
`default_nettype wire
